// file: hw/fsled_top.sv
// Fieldbus status lamp driver: pattern timing for the green and red lamps
`timescale 1ns/1ps
module fsled_top
	import fsled_pkg::*;
#(
	parameter int unsigned MS_CYCLES = MS_TICK_CYC
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire fsled_nmt_e nmt_state,
	input wire fsled_err_s err,
	output logic green_led,
	output logic red_led
);
	// A zero divider would never tick, so every pattern would freeze
	if (MS_CYCLES < 1) begin : g_bad_ms
		$error("MS_CYCLES must be at least one");
	end

	logic [31:0] div_reg, div_next;
	logic ms_tick_reg, ms_tick_next;

	always_comb begin
		div_next = div_reg + 32'h1;
		ms_tick_next = 1'b0;
		if (div_reg >= 32'(MS_CYCLES - 1)) begin
			div_next = 32'h0;
			ms_tick_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			div_reg <= 32'h0;
			ms_tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			ms_tick_reg <= ms_tick_next;
		end
	end

	// Pattern choice; red priority puts bus-off over lesser faults
	fsled_pat_e g_pat, r_pat;

	always_comb begin
		case (nmt_state)
			FSLED_NMT_INIT: g_pat = FSLED_PAT_OFF; // see RQ2
			FSLED_NMT_PREOP: g_pat = FSLED_PAT_BLINK; // see RQ2
			FSLED_NMT_STOPPED: g_pat = FSLED_PAT_FLASH1; // see RQ3
			default: g_pat = FSLED_PAT_ON; // see RQ2
		endcase
		if (err.bus_off) begin
			r_pat = FSLED_PAT_ON; // see RQ4
		end else if (err.sync_fail) begin
			r_pat = FSLED_PAT_FLASH3; // see RQ6
		end else if (err.guard_fail) begin
			r_pat = FSLED_PAT_FLASH2; // see RQ5
		end else if (err.msg_fail) begin
			r_pat = FSLED_PAT_FLASH1; // see RQ4
		end else begin
			r_pat = FSLED_PAT_OFF; // see RQ4
		end
	end

	// One sequencer per lamp, see RQ1
	fsled_seq u_green (
		.core_clk(core_clk),
		.reset(reset),
		.ms_tick(ms_tick_reg),
		.pat(g_pat),
		.lamp(green_led)
	);

	fsled_seq u_red (
		.core_clk(core_clk),
		.reset(reset),
		.ms_tick(ms_tick_reg),
		.pat(r_pat),
		.lamp(red_led)
	);

	// Steady states show on the lamp one cycle after the input is taken
	property p_init_dark;
		@(posedge core_clk) disable iff (reset)
		(nmt_state == FSLED_NMT_INIT) |=> !green_led;
	endproperty
	a_init_dark: assert property (p_init_dark) else $error("green lit in init state"); // see RQ2

	property p_oper_lit;
		@(posedge core_clk) disable iff (reset)
		(nmt_state == FSLED_NMT_OPER) |=> green_led;
	endproperty
	a_oper_lit: assert property (p_oper_lit) else $error("green dark in operational"); // see RQ2

	// Bus-off outranks every lesser fault on the red lamp
	property p_bus_off_lit;
		@(posedge core_clk) disable iff (reset)
		err.bus_off |=> red_led;
	endproperty
	a_bus_off_lit: assert property (p_bus_off_lit) else $error("red dark while bus-off"); // see RQ4
endmodule

// Phase sequencer: even phases lit, odd phases dark, last dark phase may be long
module fsled_seq
	import fsled_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ms_tick,
	input wire fsled_pat_e pat,
	output logic lamp
);
	fsled_pat_e pat_reg, pat_next;
	logic [2:0] ph_reg, ph_next;
	logic [MS_W-1:0] ms_reg, ms_next;
	logic lamp_reg, lamp_next;
	logic [2:0] end_ph;
	logic [MS_W-1:0] ph_len;

	always_comb begin
		case (pat)
			FSLED_PAT_FLASH2: end_ph = 3'h3;
			FSLED_PAT_FLASH3: end_ph = LAST_PHASE;
			default: end_ph = 3'h1;
		endcase
		// Blink has no long gap; flashes end on the 1000 ms dark phase
		if (ph_reg == end_ph && pat != FSLED_PAT_BLINK) begin
			ph_len = LONG_MS_W; // see RQ3 see RQ6 see RQ7
		end else begin
			ph_len = PHASE_MS_W; // see RQ2 see RQ7
		end
		pat_next = pat;
		ph_next = ph_reg;
		ms_next = ms_reg;
		if (pat != pat_reg) begin
			ph_next = 3'h0; // see RQ7
			ms_next = '0;
		end else if (ms_tick) begin
			if (ms_reg >= ph_len - MS_W'(1)) begin
				ms_next = '0;
				ph_next = (ph_reg >= end_ph) ? 3'h0 : ph_reg + 3'h1;
			end else begin
				ms_next = ms_reg + MS_W'(1);
			end
		end
		case (pat_next)
			FSLED_PAT_OFF: lamp_next = 1'b0;
			FSLED_PAT_ON: lamp_next = 1'b1;
			default: lamp_next = ~ph_next[0];
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pat_reg <= FSLED_PAT_OFF;
			ph_reg <= 3'h0;
			ms_reg <= '0;
			lamp_reg <= 1'b0;
		end else begin
			pat_reg <= pat_next;
			ph_reg <= ph_next;
			ms_reg <= ms_next;
			lamp_reg <= lamp_next;
		end
	end

	assign lamp = lamp_reg;

	property p_steady_on;
		@(posedge core_clk) disable iff (reset)
		(pat == FSLED_PAT_ON && pat_reg == FSLED_PAT_ON) |=> lamp;
	endproperty
	a_steady_on: assert property (p_steady_on) else $error("steady pattern not lit"); // see RQ2

	property p_off_dark;
		@(posedge core_clk) disable iff (reset)
		(pat == FSLED_PAT_OFF) |=> !lamp;
	endproperty
	a_off_dark: assert property (p_off_dark) else $error("off pattern lit"); // see RQ4

	property p_restart;
		@(posedge core_clk) disable iff (reset)
		(pat != pat_reg && pat != FSLED_PAT_OFF) |=> (ph_reg == 3'h0 && lamp);
	endproperty
	a_restart: assert property (p_restart) else $error("pattern did not restart"); // see RQ7

	property p_phase_bound;
		@(posedge core_clk) disable iff (reset)
		ph_reg <= LAST_PHASE;
	endproperty
	a_phase_bound: assert property (p_phase_bound) else $error("phase out of range"); // see RQ6

	property p_long_gap;
		@(posedge core_clk) disable iff (reset)
		(pat == pat_reg && pat == FSLED_PAT_FLASH1 && ph_reg == 3'h1 && ms_tick
			&& ms_reg == MS_W'(PHASE_MS - 1)) |=> (ph_reg == 3'h1 && !lamp);
	endproperty
	a_long_gap: assert property (p_long_gap) else $error("single flash gap too short"); // see RQ3

	property p_blink_short;
		@(posedge core_clk) disable iff (reset)
		(pat == pat_reg && pat == FSLED_PAT_BLINK && ph_reg == 3'h1 && ms_tick
			&& ms_reg == MS_W'(PHASE_MS - 1)) |=> (ph_reg == 3'h0 && lamp);
	endproperty
	a_blink_short: assert property (p_blink_short) else $error("blink dark phase wrong"); // see RQ2

	property p_ms_bound;
		@(posedge core_clk) disable iff (reset)
		ms_reg < LONG_MS_W;
	endproperty
	a_ms_bound: assert property (p_ms_bound) else $error("phase timer overran"); // see RQ7

	property p_double_wrap;
		@(posedge core_clk) disable iff (reset)
		(pat == pat_reg && pat == FSLED_PAT_FLASH2) |-> ph_reg <= 3'h3;
	endproperty
	a_double_wrap: assert property (p_double_wrap) else $error("double flash phase wrong"); // see RQ5

	// The closing dark phase of the double flash must run past 200 ms
	property p_double_gap;
		@(posedge core_clk) disable iff (reset)
		(pat == pat_reg && pat == FSLED_PAT_FLASH2 && ph_reg == 3'h3 && ms_tick
			&& ms_reg == MS_W'(PHASE_MS - 1)) |=> (ph_reg == 3'h3 && !lamp);
	endproperty
	a_double_gap: assert property (p_double_gap) else $error("double flash gap too short"); // see RQ5

	property p_triple_gap;
		@(posedge core_clk) disable iff (reset)
		(pat == pat_reg && pat == FSLED_PAT_FLASH3 && ph_reg == LAST_PHASE && ms_tick
			&& ms_reg == MS_W'(PHASE_MS - 1)) |=> (ph_reg == LAST_PHASE && !lamp);
	endproperty
	a_triple_gap: assert property (p_triple_gap) else $error("triple flash gap too short"); // see RQ6
endmodule

// file: include/fsled_pkg.sv
// Constants and types for the fieldbus status lamp driver
// Operation
// RQ1 - Drive exactly two lamps: green for node state, red for error condition.
// RQ2 - Green dark in init, lit in operational, 200/200 ms blink in pre-operational.
// RQ3 - Stopped: green repeats one 200 ms flash then 1000 ms dark.
// RQ4 - Red dark without error, lit while bus-off, single flash on message failure.
// RQ5 - Red double flash whenever guarding or heartbeat supervision has failed; the code shows bus-off and SYNC failure over it.
// RQ6 - SYNC failure: red three 200 ms flashes, 200 ms gaps, then 1000 ms dark.
// RQ7 - Double flash uses 200/200 then 1000 ms; patterns restart on condition change.
package fsled_pkg;
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned MS_TICK_CYC = CLK_HZ / 1000;
	localparam int unsigned PHASE_MS = 200;
	localparam int unsigned LONG_MS = 1000;
	localparam int unsigned MS_W = 11;
	localparam logic [MS_W-1:0] PHASE_MS_W = MS_W'(PHASE_MS);
	localparam logic [MS_W-1:0] LONG_MS_W = MS_W'(LONG_MS);
	localparam logic [2:0] LAST_PHASE = 3'h5;

	typedef enum logic [1:0] {
		FSLED_NMT_INIT,
		FSLED_NMT_PREOP,
		FSLED_NMT_STOPPED,
		FSLED_NMT_OPER
	} fsled_nmt_e;

	typedef enum logic [2:0] {
		FSLED_PAT_OFF,
		FSLED_PAT_ON,
		FSLED_PAT_BLINK,
		FSLED_PAT_FLASH1,
		FSLED_PAT_FLASH2,
		FSLED_PAT_FLASH3
	} fsled_pat_e;

	typedef struct packed {
		logic bus_off;
		logic sync_fail;
		logic guard_fail;
		logic msg_fail;
	} fsled_err_s;
endpackage

// file: tb/fsled_lamp.sv
// Lamp model: measures how long each lit or dark run of one lamp lasted
`timescale 1ns/1ps
module fsled_lamp (
	input wire logic core_clk,
	input wire logic lamp,
	output int run_len,
	output int n_edge
);
	logic last_reg;
	int cnt_reg;

	// Plain always: the first edge out of reset counts as a run end, harmless
	always @(posedge core_clk) begin
		if (lamp !== last_reg) begin
			run_len <= cnt_reg;
			n_edge <= n_edge + 1;
			cnt_reg <= 1;
		end else begin
			cnt_reg <= cnt_reg + 1;
		end
		last_reg <= lamp;
	end
endmodule

// file: tb/fsled_top_bench.sv
// Bench for the fieldbus status lamp driver
`timescale 1ns/1ps
module fsled_top_bench;
	import fsled_pkg::*;
	localparam int MSC = 4;
	localparam int PH = PHASE_MS * MSC;
	localparam int LG = LONG_MS * MSC;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	fsled_nmt_e nmt_state = FSLED_NMT_INIT;
	fsled_err_s err = '0;
	logic green_led;
	logic red_led;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;

	fsled_top #(.MS_CYCLES(MSC)) u_dut (.core_clk(core_clk), .reset(reset),
		.nmt_state(nmt_state), .err(err), .green_led(green_led), .red_led(red_led));
	fsled_lamp u_mg (.core_clk(core_clk), .lamp(green_led), .run_len(), .n_edge());
	fsled_lamp u_mr (.core_clk(core_clk), .lamp(red_led), .run_len(), .n_edge());

	initial forever #4 core_clk = ~core_clk;

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Whole run needs about 35000 cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: timeout", $time);
			conclude();
		end
	end

	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic apply(input fsled_nmt_e s, input logic [3:0] e, input bit red, input logic lvl);
		@(posedge core_clk);
		nmt_state <= s;
		err <= e;
		@(posedge core_clk);
		#1;
		check((red ? red_led : green_led) === lvl, "wrong first phase");
	endtask

	// Longer than one 200 ms phase, so any blinking shows
	task automatic hold(input bit red, input logic lvl);
		repeat (PH + PH / 2) begin
			@(negedge core_clk);
			check((red ? red_led : green_led) === lvl, "lamp not steady");
		end
	endtask

	// First lit run is skipped: it may be up to one ms tick short
	task automatic runs(input bit red, input int n, input int exp[6]);
		int e0;
		wait ((red ? red_led : green_led) === 1'b0);
		@(posedge core_clk);
		#1;
		e0 = red ? u_mr.n_edge : u_mg.n_edge;
		for (int i = 0; i < n; i++) begin
			wait ((red ? u_mr.n_edge : u_mg.n_edge) == e0 + i + 1);
			check((red ? u_mr.run_len : u_mg.run_len) == exp[i], "run length wrong");
		end
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		apply(FSLED_NMT_INIT, 4'h0, 0, 1'b0);
		hold(0, 1'b0);
		hold(1, 1'b0);
		apply(FSLED_NMT_OPER, 4'hf, 1, 1'b1);
		hold(0, 1'b1);
		hold(1, 1'b1);
		apply(FSLED_NMT_PREOP, 4'hf, 0, 1'b1);
		runs(0, 3, '{PH, PH, PH, 0, 0, 0});
		apply(FSLED_NMT_STOPPED, 4'h1, 0, 1'b1);
		runs(0, 2, '{LG, PH, 0, 0, 0, 0});
		// Red already runs the single flash; clear it so the next apply restarts it
		apply(FSLED_NMT_STOPPED, 4'h0, 1, 1'b0);
		apply(FSLED_NMT_STOPPED, 4'h1, 1, 1'b1);
		runs(1, 2, '{LG, PH, 0, 0, 0, 0});
		apply(FSLED_NMT_STOPPED, 4'h3, 1, 1'b1);
		runs(1, 4, '{PH, PH, LG, PH, 0, 0});
		apply(FSLED_NMT_STOPPED, 4'h7, 1, 1'b1);
		runs(1, 6, '{PH, PH, PH, PH, LG, PH});
		conclude();
	end
endmodule
